//--- src/stepper_pkg.sv
// Package of constants and types for the stepper phase sequencer
package stepper_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MIN_ENERGISE_MS = 50;
  localparam int unsigned MIN_ENERGISE_CYCLES =
    (MIN_ENERGISE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DWELL_W = 23;

  // ****************************************************************
  // Trigger pair encoding {a, b}
  // ****************************************************************
  typedef enum logic [1:0]
  {
    TRIG_HOME = 2'h0,
    TRIG_A    = 2'h2,
    TRIG_AB   = 2'h3,
    TRIG_B    = 2'h1
  } trig_type;

  localparam logic [1:0] TRIG_RESET  = 2'h0;
  localparam logic [1:0] PHASE_RESET = 2'h3;
  localparam logic [3:0] LINES_OFF   = 4'h0;

endpackage

//--- src/dwell_if.sv
// Interface between the sequencer and its dwell timer
interface dwell_if;
  logic start;
  logic done;
  modport owner (output start, input done);
  modport timer (input start, output done);
endinterface

//--- src/dwell_timer.sv
// Minimum energising time counter for the four-pole drive
module dwell_timer
  import stepper_pkg::*;
#(
  parameter int unsigned CYCLES = MIN_ENERGISE_CYCLES
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  dwell_if.timer    dw
);

  logic [DWELL_W-1:0] count;
  logic [DWELL_W-1:0] next_count;
  logic               next_done;
  logic               done_q;

  assign dw.done = done_q;

  always_comb
  begin
    next_count = count;
    next_done  = done_q;
    if (dw.start)
    begin
      next_count = DWELL_W'(CYCLES - 1);
      next_done  = 1'b0;
    end
    else if (count != '0)
    begin
      next_count = count - DWELL_W'(1);
    end
    else
    begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count  <= '0;
      done_q <= 1'b1;
    end
    else if (ce_i)
    begin
      count  <= next_count;
      done_q <= next_done;
    end
  end

endmodule

//--- src/stepper_phase_sequencer.sv
// Stepper phase sequencer: two-trigger drive and four-pole drive
// ****************************************************************
// What this block does
// [R1] Two triggers give four drive states
// [R2] Reset puts both triggers inactive, home
// [R3] Clockwise: home, A, AB, B, home
// [R4] Direction set only by sequence order
// [R5] One advance gives exactly one step
// [R6] Counterclockwise walks the states in reverse
// [R7] Phase energised only when both lines active
// [R8] From phase 3: zero line, then one line
// [R9] Each phase held at least 50 ms
// ****************************************************************
module stepper_phase_sequencer
  import stepper_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = MIN_ENERGISE_CYCLES
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       step_i,
  input  wire logic       ccw_i,
  input  wire logic       pole_step_i,
  input  wire logic       pole_ccw_i,
  output logic            trig_a_o,
  output logic            trig_b_o,
  output logic            step_done_o,
  output logic [1:0]      phase_o,
  output logic [3:0]      access_o,
  output logic [3:0]      winding_o,
  output logic            pole_busy_o
);

  // ****************************************************************
  // Two-trigger sequencer
  // ****************************************************************
  trig_type trig;
  trig_type next_trig;
  logic     next_step_done;

  // Clockwise successor; one trigger flips per advance [R3]
  function automatic trig_type cw_next(input trig_type cur);
    trig_type res;
    res = cur;
    unique case (cur)
      TRIG_HOME: res = TRIG_A;    // [R3]
      TRIG_A:    res = TRIG_AB;   // [R3]
      TRIG_AB:   res = TRIG_B;    // [R3]
      TRIG_B:    res = TRIG_HOME; // [R3]
    endcase
    return res;
  endfunction

  // Counterclockwise successor, the clockwise ring walked backwards [R6]
  function automatic trig_type ccw_next(input trig_type cur);
    trig_type res;
    res = cur;
    unique case (cur)
      TRIG_HOME: res = TRIG_B;    // [R6]
      TRIG_B:    res = TRIG_AB;   // [R6]
      TRIG_AB:   res = TRIG_A;    // [R6]
      TRIG_A:    res = TRIG_HOME; // [R6]
    endcase
    return res;
  endfunction

  // Direction only picks which ring is walked [R4]
  function automatic trig_type advance(input trig_type cur, input logic ccw);
    trig_type res;
    if (ccw)
    begin
      res = ccw_next(cur);
    end
    else
    begin
      res = cw_next(cur);
    end
    return res;
  endfunction

  always_comb
  begin
    next_trig      = trig;
    next_step_done = 1'b0;
    if (step_i)
    begin
      // Only the order differs between directions [R4]
      next_trig      = advance(trig, ccw_i); // [R5]
      next_step_done = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig        <= trig_type'(TRIG_RESET); // [R2]
      step_done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      trig        <= next_trig;
      step_done_o <= next_step_done;
    end
  end

  // Triggers come straight from the state flops [R1]
  assign trig_a_o = trig[1];
  assign trig_b_o = trig[0];

  // ****************************************************************
  // Four-pole drive
  // ****************************************************************
  dwell_if dw();

  dwell_timer #(
    .CYCLES (DWELL_CYCLES)
  ) u_dwell (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .dw    (dw)
  );

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       next_start;
  logic       start_q;
  logic       accept;
  logic [3:0] next_access;
  logic [3:0] next_winding;
  logic       next_busy;

  // Phase n needs lines n and n+1 both active
  function automatic logic [3:0] lines_for(input logic [1:0] ph);
    logic [3:0] l;
    l = LINES_OFF;
    l[ph]               = 1'b1;
    l[2'(ph + 2'h1)]    = 1'b1;
    return l;
  endfunction

  // Neighbouring phase; the down direction is a local choice
  function automatic logic [1:0] neighbour(input logic [1:0] ph, input logic down);
    logic [1:0] res;
    if (down)
    begin
      res = 2'(ph - 2'h1);
    end
    else
    begin
      res = 2'(ph + 2'h1);
    end
    return res;
  endfunction

  // ****************************************************************
  // Request acceptance
  // ****************************************************************
  // A request inside the dwell is dropped, so no phase is cut short [R9]
  assign accept = pole_step_i && dw.done && !start_q;

  always_comb
  begin
    next_phase = phase;
    next_start = 1'b0;
    if (accept)
    begin
      next_phase = neighbour(phase, pole_ccw_i); // [R8]
      next_start = 1'b1;
    end
  end

  assign dw.start = start_q;

  // ****************************************************************
  // Access lines and windings
  // ****************************************************************
  // Lines stay off until the first request, so home draws no current
  always_comb
  begin
    next_access = access_o;
    if (accept)
    begin
      next_access = lines_for(next_phase);
    end
  end

  // Each winding is the overlap of its two access lines [R7]
  for (genvar n = 0; n < 4; n++)
  begin : g_winding
    assign next_winding[n] = next_access[n] & next_access[(n + 1) % 4]; // [R7]
  end

  // Busy covers the start pulse and the whole count [R9]
  always_comb
  begin
    next_busy = next_start | start_q | !dw.done; // [R9]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase       <= PHASE_RESET; // [R8]
      start_q     <= 1'b0;
      access_o    <= LINES_OFF;
      winding_o   <= LINES_OFF;
      pole_busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      phase       <= next_phase;
      start_q     <= next_start;
      access_o    <= next_access;
      winding_o   <= next_winding;
      pole_busy_o <= next_busy;
    end
  end

  assign phase_o = phase;

endmodule

//--- verif/stepper_props_properties.sv
// Port checker of the stepper phase sequencer
module stepper_props
#(
  parameter int unsigned DWELL_CYCLES = 8
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       step_i,
  input wire logic       ccw_i,
  input wire logic       pole_step_i,
  input wire logic       pole_ccw_i,
  input wire logic       trig_a_o,
  input wire logic       trig_b_o,
  input wire logic       step_done_o,
  input wire logic [1:0] phase_o,
  input wire logic [3:0] access_o,
  input wire logic [3:0] winding_o,
  input wire logic       pole_busy_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned hold;
  wire         step = ce_i && step_i;
  sequence s_up;
    ce_i && pole_step_i && !pole_busy_o && !pole_ccw_i;
  endsequence
  sequence s_down;
    ce_i && pole_step_i && !pole_busy_o && pole_ccw_i;
  endsequence
  // Saturates so a long idle spell cannot wrap
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      hold <= DWELL_CYCLES;
    else if ($changed(phase_o))
      hold <= 0;
    else if (hold < DWELL_CYCLES)
      hold <= hold + 1;
  a_home_at_release: assert property ($fell(rst_i) |-> {trig_a_o, trig_b_o, phase_o} == 4'h3)
    else $error("not home after reset");
  a_cw_order: assert property (step && !ccw_i |=>
    step_done_o && {trig_a_o, trig_b_o} == {!$past(trig_b_o), $past(trig_a_o)})
    else $error("bad cw step");
  a_ccw_order: assert property (step && ccw_i |=>
    step_done_o && {trig_a_o, trig_b_o} == {$past(trig_b_o), !$past(trig_a_o)})
    else $error("bad ccw step");
  a_idle_hold: assert property (!step |=> $stable({trig_a_o, trig_b_o}) && !step_done_o)
    else $error("move without step");
  a_one_flip: assert property ($changed({trig_a_o, trig_b_o}) |->
    $onehot({trig_a_o ^ $past(trig_a_o), trig_b_o ^ $past(trig_b_o)}))
    else $error("two triggers flipped");
  a_both_lines: assert property ((winding_o & ~(access_o & {access_o[0], access_o[3:1]})) == 4'h0)
    else $error("winding without lines");
  a_pole_up: assert property (s_up |=> phase_o == $past(phase_o) + 2'h1 && pole_busy_o)
    else $error("bad pole step");
  a_pole_down: assert property (s_down |=> phase_o == $past(phase_o) - 2'h1 && pole_busy_o)
    else $error("bad pole step down");
  a_dwell_min: assert property ($changed(phase_o) |-> hold >= DWELL_CYCLES - 1)
    else $error("phase held too briefly");
endmodule
bind stepper_phase_sequencer stepper_props #(.DWELL_CYCLES(DWELL_CYCLES)) u_props (.*);

//--- verif/motor_model.sv
// Rotor position model driven by the trigger pair
module motor_model
(
  input  wire logic clk_i,
  input  wire logic a_i,
  input  wire logic b_i,
  output int        pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last = 2'h0;
  initial pos_o = 0;
  // ****
  // One step per advance, order gives direction
  // ****
  always @(posedge clk_i)
  begin
    if ({a_i, b_i} == {!last[0], last[1]}) pos_o <= pos_o + 1;
    else if ({a_i, b_i} == {last[0], !last[1]}) pos_o <= pos_o - 1;
    last <= {a_i, b_i};
  end
endmodule

//--- verif/tb.sv
// Self-checking testbench of the stepper phase sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, step_i = 1'b0, ccw_i = 1'b0;
  logic        pole_step_i = 1'b0, pole_ccw_i = 1'b0;
  logic        trig_a_o, trig_b_o, step_done_o, pole_busy_o;
  logic [1:0]  phase_o;
  logic [3:0]  access_o, winding_o;
  int          error_cnt = 0, cmp_count = 0, pos;
  wire  [10:0] pst = {phase_o, access_o, winding_o, pole_busy_o};
  wire  [10:0] tst = {8'h00, trig_a_o, trig_b_o, step_done_o};
  stepper_phase_sequencer #(.DWELL_CYCLES(8)) dut (.*);
  motor_model model (.clk_i, .a_i(trig_a_o), .b_i(trig_b_o), .pos_o(pos));
  // ****
  // Tasks
  // ****
  task automatic chk(string n, logic [10:0] e, logic [10:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Back to back steps; x holds the pair expected after each
  task automatic run_steps(logic d, logic [7:0] x);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_i);
      step_i <= i < 4;
      ccw_i <= d;
      #1;
      if (i > 0) chk("trig", {8'h00, x[9-2*i -: 2], 1'b1}, tst);
    end
  endtask
  task automatic req(logic d);
    @(posedge clk_i);
    pole_step_i <= 1'b1;
    pole_ccw_i <= d;
    @(posedge clk_i);
    pole_step_i <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 30 && pole_busy_o !== 1'b0; i++)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic t_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    step_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("freeze", 11'h000, tst);
    @(posedge clk_i);
    ce_i <= 1'b1;
    step_i <= 1'b0;
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    step_i <= 1'b1;
    @(posedge clk_i);
    step_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rehome", 11'h000, tst);
    chk("repole", 11'h600, pst);
  endtask
  task automatic t_steps();
    chk("home", 11'h000, tst);
    run_steps(1'b0, 8'hB4);
    @(posedge clk_i);
    #1;
    chk("pos", 11'h004, pos[10:0]);
    run_steps(1'b1, 8'h78);
    @(posedge clk_i);
    #1;
    chk("back", 11'h000, pos[10:0]);
  endtask
  task automatic t_pole();
    chk("reset", 11'h600, pst);
    req(1'b0);
    chk("up", 11'h063, pst);
    req(1'b0);
    chk("busy", 11'h063, pst);
    wait_idle();
    req(1'b0);
    chk("next", 11'h2C5, pst);
    wait_idle();
    req(1'b1);
    chk("down", 11'h063, pst);
    wait_idle();
  endtask
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #50us;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_pole();
    t_steps();
    t_freeze();
    t_reset();
    report_and_stop();
  end
endmodule
